//--- adcop_pkg.sv
// shared constants of the converter output pipeline control
package adcop_pkg;

    // ========================================
    // register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0C;
    localparam logic [7:0]  ADDR_READBACK  = 8'h10;

    // ========================================
    // control fields
    localparam int          CTRL_READOUT   = 0;
    localparam int          CTRL_LOWLAT    = 1;
    localparam int          CTRL_GAIN      = 2;
    localparam int          CTRL_OFFS      = 3;
    localparam int          CTRL_PDI_LONG  = 4;
    localparam int          CTRL_W         = 5;
    localparam logic [4:0]  CTRL_RESET     = 5'h02;

    // status fields
    localparam int          ST_VALID       = 0;
    localparam int          ST_TWOS        = 1;
    localparam int          ST_LVDS        = 2;
    localparam int          ST_RB_BUSY     = 3;
    localparam int          ST_LAT_LSB     = 8;

    // interrupt fields
    localparam int          IRQ_OVR        = 0;
    localparam int          IRQ_WAKE       = 1;
    localparam int          IRQ_W          = 2;

    // strap fields
    localparam int          STRAP_TWOS     = 0;
    localparam int          STRAP_LVDS     = 1;

    // ========================================
    // pipeline latencies in sample clocks
    localparam logic [4:0]  LAT_LOW        = 5'd10;
    localparam logic [4:0]  LAT_GAIN       = 5'd16;
    localparam logic [4:0]  LAT_GAIN_OFS   = 5'd17;
    localparam logic [4:0]  LAT_PDI_EXTRA  = 5'd1;

    // readback word
    localparam int          RB_W           = 16;
    localparam logic [4:0]  RB_BITS        = 5'd16;

    // ========================================
    // wake-up times
    localparam int          CLK_MHZ        = 100;
    localparam int          STBY_WAKE_US   = 5;
    localparam int          STBY_WAKE_MAX_US = 25;
    localparam int          PDN_WAKE_US    = 100;
    localparam int          PDN_WAKE_MAX_US  = 500;
    localparam int          WAKE_CNT_W     = 20;
    localparam logic [19:0] STBY_WAKE_CYC  = 20'(STBY_WAKE_US * CLK_MHZ);
    localparam int          PDN_WAKE_CYC   = PDN_WAKE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        WAKE_RUN  = 2'b00,
        WAKE_STBY = 2'b01,
        WAKE_PDN  = 2'b10,
        WAKE_WAIT = 2'b11
    } adcop_wake_t;

endpackage

//--- adcop_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adcop_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

//--- adcop_dly_mem.sv
// delay-line memory with registered read data
`timescale 1ns/1ps
module adcop_dly_mem #(
    parameter int W  = 15,
    parameter int AW = 5
) (
    // clock
    input  wire logic          clk_i,
    input  wire logic          ce_i,
    // write side
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    // read side
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);
    logic [W-1:0] mem_q [2**AW];

    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

//--- adcop_ctrl.sv
// converter output pipeline control: latency line, pin mux, wake-up, registers
// Contract
// - the strap picks the number format and whether the outputs run as LVDS or CMOS.
// - after reset and with readback disabled the shared pin shows the out-of-range flag.
// - with readback enabled the shared pin shifts out register contents serially.
// - low-latency mode is on after reset and delays each sample by 10 sample clocks.
// - low latency off with gain on and offset correction off gives 16 sample clocks.
// - low latency off with gain and offset correction on gives 17 sample clocks.
// - when the clock propagation delay exceeds one sample period the latency grows by one.
// - output data is valid at most 25 us after leaving standby.
// - output data is valid at most 500 us after leaving global power-down.
// - in CMOS mode each sample leaves as a 12- or 14-bit word with an output clock.
// - in LVDS mode data and clock keep the same relation with low latency on or off.
// - while the hardware reset pin is high the control and interrupt mask registers stay at defaults.
// - with hardware reset high the serial data pin is a standby control, else serial data.
`timescale 1ns/1ps
module adcop_ctrl
    import adcop_pkg::*;
#(
    parameter int RES          = 14,
    parameter int AW           = 5,
    parameter int PDN_WAKE_CNT = PDN_WAKE_CYC
) (
    // clock, reset, enable
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           ce_i,
    // wishbone slave
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic      [31:0]    wb_dat_o,
    output logic                wb_ack_o,
    // converter core and pins
    input  wire logic           sample_clk_i,
    input  wire logic [RES-1:0] sample_word_i,
    input  wire logic           sample_ovr_i,
    input  wire logic [1:0]     format_interface_select_i,
    input  wire logic           hw_reset_i,
    input  wire logic           serial_data_in_i,
    input  wire logic           serial_enable_in_i,
    input  wire logic           global_power_down_i,
    // output pins
    output logic      [RES-1:0] sample_bits_o,
    output logic                output_sample_clock_o,
    output logic                range_flag_readout_pin_o,
    output logic                lvds_mode_o,
    output logic                twos_comp_o,
    output logic                data_valid_o,
    output logic                irq_o
);
    // ========================================
    // elaboration checks
    if (RES != 12 && RES != 14) begin : g_bad_res
        $error("resolution must be 12 or 14");
    end
    if ((2 ** AW) < 32'(LAT_GAIN_OFS + LAT_PDI_EXTRA + 5'd2)) begin : g_bad_aw
        $error("delay memory too shallow");
    end
    if (PDN_WAKE_CNT < 1 || PDN_WAKE_CNT > PDN_WAKE_MAX_US * CLK_MHZ) begin : g_bad_pdn
        $error("power-down wake count out of range");
    end

    // ========================================
    // pin synchronisation
    localparam int SW = RES + 8;
    logic [SW-1:0] pins_s;
    adcop_sync #(.W(SW)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({serial_enable_in_i, global_power_down_i, serial_data_in_i, hw_reset_i,
                 format_interface_select_i, sample_ovr_i, sample_word_i, sample_clk_i}),
        .q_o   (pins_s)
    );
    wire           sclk_s  = pins_s[0];
    wire [RES-1:0] word_s  = pins_s[RES:1];
    wire           ovr_s   = pins_s[RES+1];
    wire [1:0]     strap_s = pins_s[RES+3:RES+2];
    wire           hwrst_s = pins_s[RES+4];
    wire           serial_data_in_s = pins_s[RES+5];
    wire           pdn_s   = pins_s[RES+6];

    // ========================================
    // sample clock edges
    logic sclk_q;
    logic oclk_q;
    logic [1:0] fmt_cap_q;
    logic [1:0] strap_q;
    wire  rise = sclk_s & ~sclk_q;
    wire  fall = ~sclk_s & sclk_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q    <= 1'b0;
            oclk_q    <= 1'b0;
            fmt_cap_q <= 2'b00;
            strap_q   <= 2'b00;
        end else if (ce_i) begin
            sclk_q <= sclk_s;
            oclk_q <= sclk_q;
            if (fmt_cap_q != 2'b11) begin
                fmt_cap_q <= fmt_cap_q + 2'b01;
                strap_q   <= (fmt_cap_q == 2'b10) ? strap_s : strap_q;
            end
        end
    end

    // ========================================
    // control registers and latency
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [RB_W-1:0]   rb_sr_q;
    logic [4:0]        rb_cnt_q;
    wire  lowlat  = ctrl_q[CTRL_LOWLAT];
    wire  readout = ctrl_q[CTRL_READOUT];
    wire [4:0] lat_core = lowlat ? LAT_LOW : (ctrl_q[CTRL_OFFS] ? LAT_GAIN_OFS : LAT_GAIN);
    wire [4:0] lat      = lat_core + (ctrl_q[CTRL_PDI_LONG] ? LAT_PDI_EXTRA : 5'd0);

    // ========================================
    // wishbone decode
    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = req & wb_we_i;
    wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wbits   = wb_dat_i & wmask;
    wire        wr_ctrl = wr && (wb_adr_i == ADDR_CTRL);
    wire        wr_stat = wr && (wb_adr_i == ADDR_IRQ_STAT);
    wire        wr_mask = wr && (wb_adr_i == ADDR_IRQ_MASK);
    wire        wr_rb   = wr && (wb_adr_i == ADDR_READBACK) && (rb_cnt_q == 5'd0);
    wire [CTRL_W-1:0] ctrl_d = (ctrl_q & ~wmask[CTRL_W-1:0]) | wbits[CTRL_W-1:0];
    wire [IRQ_W-1:0]  mask_d = (irq_mask_q & ~wmask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
    adcop_wake_t wake_q;
    wire [31:0] status_w = {19'h0_0000, lat, 4'h0, (rb_cnt_q != 5'd0), strap_q[STRAP_LVDS],
                            strap_q[STRAP_TWOS], (wake_q == WAKE_RUN)};
    wire [31:0] rd_mux  = (wb_adr_i == ADDR_CTRL)     ? 32'(ctrl_q)     :
                          (wb_adr_i == ADDR_STATUS)   ? status_w        :
                          (wb_adr_i == ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
                          (wb_adr_i == ADDR_IRQ_MASK) ? 32'(irq_mask_q) :
                          (wb_adr_i == ADDR_READBACK) ? 32'(rb_sr_q)    : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || hwrst_s) begin
            ctrl_q     <= CTRL_RESET;
            irq_mask_q <= '0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_d;
            end
            if (wr_mask) begin
                irq_mask_q <= mask_d;
            end
        end
    end

    // ========================================
    // delay line
    logic [AW-1:0]  ptr_q;
    logic [RES:0]   cap_q;
    logic           cap_v_q;
    logic [RES:0]   dly_w;
    wire  [AW-1:0]  raddr = ptr_q - AW'(lat) + AW'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q   <= '0;
            cap_q   <= '0;
            cap_v_q <= 1'b0;
        end else if (ce_i) begin
            if (rise) begin
                ptr_q <= ptr_q + AW'(1);
            end
            cap_v_q <= fall;
            if (fall) begin
                cap_q <= {ovr_s, word_s};
            end
        end
    end

    adcop_dly_mem #(.W(RES + 1), .AW(AW)) u_mem (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (cap_v_q),
        .waddr_i (ptr_q),
        .wdata_i (cap_q),
        .raddr_i (raddr),
        .rdata_o (dly_w)
    );

    // ========================================
    // output stage
    logic ovr_out_q;
    logic rb_bit_q;
    wire [RES-1:0] fmt_word = strap_q[STRAP_TWOS] ? {~dly_w[RES-1], dly_w[RES-2:0]} : dly_w[RES-1:0];
    wire ovr_evt = rise & dly_w[RES] & (wake_q == WAKE_RUN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_bits_o            <= '0;
            ovr_out_q                <= 1'b0;
            rb_bit_q                 <= 1'b0;
            output_sample_clock_o    <= 1'b0;
            range_flag_readout_pin_o <= 1'b0;
            lvds_mode_o              <= 1'b0;
            twos_comp_o              <= 1'b0;
            data_valid_o             <= 1'b0;
        end else if (ce_i) begin
            if (rise) begin
                sample_bits_o <= fmt_word;
                ovr_out_q     <= dly_w[RES];
                rb_bit_q      <= rb_sr_q[RB_W-1];
            end
            output_sample_clock_o    <= oclk_q;
            range_flag_readout_pin_o <= readout ? rb_bit_q : ovr_out_q;
            lvds_mode_o              <= strap_q[STRAP_LVDS];
            twos_comp_o              <= strap_q[STRAP_TWOS];
            data_valid_o             <= (wake_q == WAKE_RUN);
        end
    end

    // ========================================
    // serial readback shifter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rb_sr_q  <= '0;
            rb_cnt_q <= 5'd0;
        end else if (ce_i) begin
            if (wr_rb) begin
                rb_sr_q  <= wbits[RB_W-1:0];
                rb_cnt_q <= RB_BITS;
            end else if (rise && readout && rb_cnt_q != 5'd0) begin
                rb_sr_q  <= {rb_sr_q[RB_W-2:0], 1'b0};
                rb_cnt_q <= rb_cnt_q - 5'd1;
            end
        end
    end

    // ========================================
    // standby and power-down wake-up
    logic [WAKE_CNT_W-1:0] wcnt_q;
    wire standby = hwrst_s & serial_data_in_s;
    wire wake_evt = (wake_q == WAKE_WAIT) && !pdn_s && !standby && (wcnt_q == WAKE_CNT_W'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= WAKE_RUN;
            wcnt_q <= '0;
        end else if (ce_i) begin
            unique case (wake_q)
                WAKE_RUN: begin
                    if (pdn_s) begin
                        wake_q <= WAKE_PDN;
                    end else if (standby) begin
                        wake_q <= WAKE_STBY;
                    end
                end
                WAKE_STBY: begin
                    if (pdn_s) begin
                        wake_q <= WAKE_PDN;
                    end else if (!standby) begin
                        wake_q <= WAKE_WAIT;
                        wcnt_q <= STBY_WAKE_CYC;
                    end
                end
                WAKE_PDN: begin
                    if (!pdn_s) begin
                        wake_q <= WAKE_WAIT;
                        wcnt_q <= WAKE_CNT_W'(PDN_WAKE_CNT);
                    end
                end
                WAKE_WAIT: begin
                    if (pdn_s) begin
                        wake_q <= WAKE_PDN;
                    end else if (standby) begin
                        wake_q <= WAKE_STBY;
                    end else if (wake_evt) begin
                        wake_q <= WAKE_RUN;
                    end else begin
                        wcnt_q <= wcnt_q - WAKE_CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // ========================================
    // interrupts
    wire [IRQ_W-1:0] evt = {wake_evt, ovr_evt};
    wire [IRQ_W-1:0] clr = wr_stat ? wbits[IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            irq_o      <= 1'b0;
        end else if (ce_i) begin
            irq_stat_q <= (irq_stat_q & ~clr) | evt;
            irq_o      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ========================================
    // checks
    chk_strap_lvds: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && $past(fmt_cap_q == 2'b11) |-> lvds_mode_o == $past(strap_q[STRAP_LVDS]))
        else $error("lvds mode output does not follow strap");
    chk_flag_pin_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && !$past(readout) |-> range_flag_readout_pin_o == $past(ovr_out_q))
        else $error("shared pin does not carry range flag");
    chk_flag_pin_rb: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && $past(readout) |-> range_flag_readout_pin_o == $past(rb_bit_q))
        else $error("shared pin does not carry readback bit");
    chk_lowlat_default: assert property (@(posedge clk_i)
        rst_i |=> lowlat && lat_core == 5'd10)
        else $error("low latency not default after reset");
    chk_lat_gain: assert property (@(posedge clk_i) disable iff (rst_i)
        !lowlat && !ctrl_q[CTRL_OFFS] |-> lat_core == 5'd16)
        else $error("gain latency wrong");
    chk_lat_gain_ofs: assert property (@(posedge clk_i) disable iff (rst_i)
        !lowlat && ctrl_q[CTRL_OFFS] |-> lat_core == 5'd17)
        else $error("gain and offset latency wrong");
    chk_pdi_extra: assert property (@(posedge clk_i) disable iff (rst_i)
        lat == lat_core + (ctrl_q[CTRL_PDI_LONG] ? 5'd1 : 5'd0))
        else $error("propagation delay cycle not added");
    chk_stby_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wake_q == WAKE_STBY && !pdn_s && !standby |=> wcnt_q == 20'd500 && wake_q == WAKE_WAIT)
        else $error("standby wake count wrong");
    chk_pdn_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wake_q == WAKE_PDN && !pdn_s |=> wake_q == WAKE_WAIT && wcnt_q <= 20'd50000)
        else $error("power-down wake count too long");
    chk_hwrst_default: assert property (@(posedge clk_i) disable iff (rst_i)
        hwrst_s |=> ctrl_q == CTRL_RESET)
        else $error("registers not held at default");
endmodule

//--- adcop_rx_model.sv
// capture model of the receiving logic behind the output pins
`timescale 1ns/1ps
module adcop_rx_model #(
    parameter int RES = 14
) (
    // clock
    input  wire logic           clk_i,
    // converter output pins
    input  wire logic [RES-1:0] sample_bits_i,
    input  wire logic           output_sample_clock_i,
    input  wire logic           range_flag_readout_pin_i,
    input  wire logic           data_valid_i,
    // captured sample
    output logic      [RES-1:0] cap_word_o,
    output logic                cap_flag_o,
    output logic                cap_stb_o
);
    logic oclk_q;
    wire  rise = output_sample_clock_i & ~oclk_q;

    // ========================================
    // capture on output clock rise
    always_ff @(posedge clk_i) begin
        oclk_q    <= output_sample_clock_i;
        cap_stb_o <= rise & data_valid_i;
        if (rise) begin
            cap_word_o <= sample_bits_i;
            cap_flag_o <= range_flag_readout_pin_i;
        end
    end
endmodule

//--- test_adc_output_pipeline_ctrl.sv
// self-checking bench of the converter output pipeline control
`timescale 1ns/1ps
module test_adc_output_pipeline_ctrl;
    import adcop_pkg::*;
    localparam int RES = 14;
    localparam int PDN = 50;

    // ========================================
    // signals
    logic            clk_i  = 1'h0;
    logic            rst_i  = 1'h1;
    logic            cyc    = 1'h0;
    logic            stb    = 1'h0;
    logic            we     = 1'h0;
    logic [7:0]      adr    = 8'h00;
    logic [31:0]     wdat   = 32'h0000_0000;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    logic            sclk   = 1'h0;
    logic [RES-1:0]  word   = '0;
    logic            ovr    = 1'h0;
    logic            ovr_en = 1'h1;
    logic [1:0]      strap  = 2'h0;
    logic            hw_rst = 1'h0;
    logic            serial_data_in  = 1'h0;
    logic            pdn    = 1'h0;
    logic [RES-1:0]  bits;
    logic            oclk, rpin, lvds, twos, valid, irq;
    logic [RES-1:0]  cap_word;
    logic            cap_flag, cap_stb;
    logic [31:0]     rdat;
    int              n      = 0;
    int              n_fail = 0;
    int              n_tests = 0;

    adcop_ctrl #(.RES(RES), .PDN_WAKE_CNT(PDN)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_clk_i(sclk), .sample_word_i(word), .sample_ovr_i(ovr),
        .format_interface_select_i(strap), .hw_reset_i(hw_rst),
        .serial_data_in_i(serial_data_in), .serial_enable_in_i(1'h1),
        .global_power_down_i(pdn), .sample_bits_o(bits),
        .output_sample_clock_o(oclk), .range_flag_readout_pin_o(rpin),
        .lvds_mode_o(lvds), .twos_comp_o(twos), .data_valid_o(valid), .irq_o(irq));

    adcop_rx_model #(.RES(RES)) rx_u (
        .clk_i(clk_i), .sample_bits_i(bits), .output_sample_clock_i(oclk),
        .range_flag_readout_pin_i(rpin), .data_valid_i(valid),
        .cap_word_o(cap_word), .cap_flag_o(cap_flag), .cap_stb_o(cap_stb));

    // ========================================
    // clocks and sample source
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        forever begin
            repeat (8) @(posedge clk_i);
            sclk <= ~sclk;
            if (!sclk) begin
                n++;
                word <= RES'(n);
                ovr  <= n[0] & ovr_en;
            end
        end
    end

    // ========================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'h1 && t < 100);
        q = wb_dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (t >= 100) chk("wb ack", 0, 1);
    endtask

    task automatic cap();
        int t;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (cap_stb !== 1'h1 && t < 100);
    endtask

    task automatic do_rst(input logic [1:0] s);
        @(posedge clk_i);
        strap <= s;
        rst_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic t_reset();
        wb(0, ADDR_CTRL, 0, rdat);
        chk("ctrl reset", rdat, 32'h0000_0002);
        wb(0, ADDR_IRQ_MASK, 0, rdat);
        chk("mask reset", rdat, 32'h0000_0000);
        wb(1, 8'h40, 32'hFFFF_FFFF, rdat);
        wb(0, 8'h40, 0, rdat);
        chk("unmapped read", rdat, 32'h0000_0000);
        wb(0, ADDR_STATUS, 0, rdat);
        chk("status mode", rdat[2:0], 3'h1);
        $display("test reset done");
    endtask

    task automatic t_lat(input logic [31:0] c, input int l, input logic inv);
        logic [RES-1:0] e;
        wb(1, ADDR_CTRL, c, rdat);
        wb(0, ADDR_STATUS, 0, rdat);
        chk("latency field", rdat[12:8], l[4:0]);
        repeat (24) cap();
        repeat (4) begin
            cap();
            e = RES'(n - l);
            e[RES-1] ^= inv;
            chk("sample word", cap_word, e);
            chk("range flag", cap_flag, e[0]);
        end
        $display("test latency %0d done", l);
    endtask

    task automatic t_irq();
        wb(1, ADDR_IRQ_MASK, 0, rdat);
        repeat (24) cap();
        wb(0, ADDR_IRQ_STAT, 0, rdat);
        chk("range status", rdat[IRQ_OVR], 1);
        chk("irq masked", irq, 0);
        wb(1, ADDR_IRQ_MASK, 32'h0000_0001, rdat);
        repeat (3) @(posedge clk_i);
        chk("irq raised", irq, 1);
        ovr_en <= 1'h0;
        repeat (24) cap();
        wb(1, ADDR_IRQ_STAT, 32'h0000_0003, rdat);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", irq, 0);
        wb(0, ADDR_IRQ_STAT, 0, rdat);
        chk("status cleared", rdat[IRQ_OVR], 0);
        $display("test interrupt done");
    endtask

    task automatic t_rb();
        logic [23:0] sh;
        int hit;
        sh = '0;
        hit = 0;
        wb(1, ADDR_CTRL, 32'h0000_0003, rdat);
        wb(1, ADDR_READBACK, 32'h0000_A5C3, rdat);
        wb(0, ADDR_STATUS, 0, rdat);
        chk("readback busy", rdat[ST_RB_BUSY], 1);
        repeat (24) begin
            cap();
            sh = {sh[22:0], cap_flag};
        end
        for (int i = 0; i <= 8; i++) begin
            if (sh[i+:16] === 16'hA5C3) hit = 1;
        end
        chk("readback bits", 32'(hit), 1);
        ovr_en <= 1'h1;
        t_lat(32'h0000_0002, 10, 0);
        $display("test readback done");
    endtask

    task automatic t_hw();
        @(posedge clk_i);
        hw_rst <= 1'h1;
        repeat (4) @(posedge clk_i);
        wb(1, ADDR_CTRL, 32'h0000_000D, rdat);
        wb(0, ADDR_CTRL, 0, rdat);
        chk("ctrl held", rdat, 32'h0000_0002);
        chk("no standby", valid, 1);
        hw_rst <= 1'h0;
        serial_data_in <= 1'h1;
        repeat (20) @(posedge clk_i);
        chk("serial data only", valid, 1);
        serial_data_in <= 1'h0;
        $display("test hardware reset pin done");
    endtask

    task automatic t_wake(input logic p, input int lim);
        int t;
        t = 0;
        @(posedge clk_i);
        pdn <= p;
        hw_rst <= ~p;
        serial_data_in <= ~p;
        repeat (20) @(posedge clk_i);
        chk("valid in low power", valid, 0);
        pdn <= 1'h0;
        serial_data_in <= 1'h0;
        while (valid !== 1'h1 && t < lim + 100) begin
            @(posedge clk_i);
            t++;
        end
        chk("wake time", 32'(t <= lim), 1);
        hw_rst <= 1'h0;
        repeat (3) @(posedge clk_i);
        wb(0, ADDR_IRQ_STAT, 0, rdat);
        chk("wake status", rdat[IRQ_WAKE], 1);
        wb(1, ADDR_IRQ_STAT, 32'h0000_0002, rdat);
        $display("test wake %0d done", p);
    endtask

    // ========================================
    // main sequence and watchdog
    initial begin
        do_rst(2'h0);
        chk("cmos mode", lvds, 0);
        chk("offset binary", twos, 0);
        t_reset();
        t_lat(32'h0000_0002, 10, 0);
        t_lat(32'h0000_0004, 16, 0);
        t_lat(32'h0000_000C, 17, 0);
        t_lat(32'h0000_0012, 11, 0);
        t_irq();
        t_rb();
        t_hw();
        t_wake(0, STBY_WAKE_MAX_US * CLK_MHZ);
        t_wake(1, PDN * 5);
        do_rst(2'h3);
        chk("lvds mode", lvds, 1);
        chk("twos complement", twos, 1);
        t_lat(32'h0000_0002, 10, 1);
        t_lat(32'h0000_0004, 16, 1);
        end_of_test();
    end

    initial begin
        #500000;
        chk("watchdog", 0, 1);
        end_of_test();
    end
endmodule
